// ### src/hpg_consts.svh
// offsets, field positions, reset values and timing counts of the host-port pin block
`ifndef HPG_CONSTS_SVH
`define HPG_CONSTS_SVH

`define HPG_ADDR_W            8
`define HPG_DATA_W            16

`define HPG_OFS_DIR           8'h00
`define HPG_OFS_DATA          8'h04
`define HPG_OFS_INT_EN        8'h08
`define HPG_OFS_INT_INV       8'h0c
`define HPG_OFS_BANK_EN       8'h10
`define HPG_OFS_MODE          8'h14
`define HPG_OFS_CTRL_DIR      8'h18
`define HPG_OFS_STATUS        8'h1c
`define HPG_OFS_MASK          8'h20

`define HPG_BIT_STROBE        2
`define HPG_BIT_BANK_LO       0
`define HPG_BIT_BANK_HI       1
`define HPG_BIT_BANK_STROBE   2
`define HPG_BIT_MODE_MUX8     0
`define HPG_BIT_CTRL_STROBE   0
`define HPG_BIT_STAT_CPU      0

`define HPG_RST_DIR           16'h0000
`define HPG_RST_DATA          16'h0000
`define HPG_RST_INT           16'h0000
`define HPG_RST_BANK          3'h0
`define HPG_RST_MODE          1'h0
`define HPG_RST_CTRL          1'h0
`define HPG_RST_STAT          1'h0

`define HPG_SYNC_STAGES       2

`endif

// ### src/hpg_pkg.sv
// types shared by the host-port pin block
package hpg_pkg;

  typedef logic [15:0] hpg_word_t;

  typedef struct packed {
    hpg_word_t  dir;
    hpg_word_t  dataOut;
    logic       intEn;
    logic       intInv;
    logic [2:0] bankEn;
    logic       mux8;
    logic       ctrlDir;
    logic       status;
    logic       mask;
    logic       reqPrev;
    logic       hostBitPrev;
    hpg_word_t  haOut;
    hpg_word_t  haOe;
    logic       irq;
    hpg_word_t  rdata;
  } hpg_state_s;

endpackage

// ### src/hpg_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`include "hpg_consts.svh"
module hpg_sync #(
  parameter int WIDTH = 17
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] stage_reg [`HPG_SYNC_STAGES];

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stage_reg[0] <= '0;
      stage_reg[1] <= '0;
    end else begin
      stage_reg[0] <= pinIn;
      stage_reg[1] <= stage_reg[0];
    end
  end

  assign pinSync = stage_reg[1];
endmodule

// ### src/hpg_gpio.sv
// host-port pin block: address-pin gpio and address-strobe interrupt
`timescale 1ns/1ps
`include "hpg_consts.svh"
module hpg_gpio
  import hpg_pkg::*;
#(
  parameter bit HAS_ADDR_PINS = 1'b1
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [`HPG_ADDR_W-1:0] regAddr,
  input  wire logic [`HPG_DATA_W-1:0] regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [`HPG_DATA_W-1:0] regRdata,
  input  wire logic [15:0]            haIn,
  output logic      [15:0]            haOut,
  output logic      [15:0]            haOe,
  input  wire logic                   strobeIn,
  input  wire logic                   hostIntBit,
  output logic                        cpuIrq
);

  localparam hpg_state_s ST_RESET = '{
    dir:         `HPG_RST_DIR,
    dataOut:     `HPG_RST_DATA,
    intEn:       1'h0,
    intInv:      1'h0,
    bankEn:      `HPG_RST_BANK,
    mux8:        `HPG_RST_MODE,
    ctrlDir:     `HPG_RST_CTRL,
    status:      `HPG_RST_STAT,
    mask:        1'h0,
    reqPrev:     1'h0,
    hostBitPrev: 1'h0,
    haOut:       16'h0000,
    haOe:        16'h0000,
    irq:         1'h0,
    rdata:       16'h0000
  };

  hpg_state_s st_reg;
  hpg_state_s st_next;

  logic [16:0] pinSync;
  hpg_word_t   haSync;
  logic        strobeSync;
  hpg_word_t   bankMask;
  logic        strobeReq;
  logic        hostRise;

  // address pins and the strobe pin come from the host, another clock domain
  hpg_sync #(
    .WIDTH (17)
  ) u_sync (
    .clk     (clk),
    .rstn    (rstn),
    .pinIn   ({strobeIn, haIn}),
    .pinSync (pinSync)
  );

  assign haSync     = pinSync[15:0];
  assign strobeSync = pinSync[16];

  function automatic logic hit(input logic [`HPG_ADDR_W-1:0] a,
                               input logic [`HPG_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // each byte bank usable only when its enable is set, in 16-bit mode, on a part with pins
  always_comb begin
    bankMask = {{8{st_reg.bankEn[`HPG_BIT_BANK_HI]}}, {8{st_reg.bankEn[`HPG_BIT_BANK_LO]}}};
    if (st_reg.mux8 || !HAS_ADDR_PINS) begin
      bankMask = 16'h0000;
    end
  end

  // level request from the strobe pin; the pin only exists in 8-bit mode
  assign strobeReq = st_reg.intEn
                   && st_reg.bankEn[`HPG_BIT_BANK_STROBE]
                   && !st_reg.ctrlDir
                   && st_reg.mux8
                   && (st_reg.intInv ? strobeSync : !strobeSync);

  // host interrupt bit is logic on this clock, so no synchroniser
  assign hostRise = hostIntBit && !st_reg.hostBitPrev;

  always_comb begin
    st_next = st_reg;
    st_next.reqPrev     = strobeReq;
    st_next.hostBitPrev = hostIntBit;

    // only this cpu port writes these registers, except status, which strobe and host interrupt events also set below
    if (regWr) begin
      if (hit(regAddr, `HPG_OFS_DIR) && HAS_ADDR_PINS) begin
        st_next.dir = regWdata;
      end
      if (hit(regAddr, `HPG_OFS_DATA) && HAS_ADDR_PINS) begin
        // bits of input pins keep their value
        st_next.dataOut = (st_reg.dataOut & ~st_reg.dir) | (regWdata & st_reg.dir);
      end
      if (hit(regAddr, `HPG_OFS_INT_EN)) begin
        st_next.intEn = regWdata[`HPG_BIT_STROBE];
      end
      if (hit(regAddr, `HPG_OFS_INT_INV)) begin
        st_next.intInv = regWdata[`HPG_BIT_STROBE];
      end
      if (hit(regAddr, `HPG_OFS_BANK_EN)) begin
        st_next.bankEn = regWdata[2:0];
      end
      if (hit(regAddr, `HPG_OFS_MODE)) begin
        st_next.mux8 = regWdata[`HPG_BIT_MODE_MUX8];
      end
      if (hit(regAddr, `HPG_OFS_CTRL_DIR)) begin
        st_next.ctrlDir = regWdata[`HPG_BIT_CTRL_STROBE];
      end
      if (hit(regAddr, `HPG_OFS_STATUS) && regWdata[`HPG_BIT_STAT_CPU]) begin
        st_next.status = 1'b0;
      end
      if (hit(regAddr, `HPG_OFS_MASK)) begin
        st_next.mask = regWdata[`HPG_BIT_STAT_CPU];
      end
    end

    // an event in the clearing cycle wins over the clear
    if ((strobeReq && !st_reg.reqPrev) || hostRise) begin
      st_next.status = 1'b1;
    end

    st_next.rdata = 16'h0000;
    if (regRd) begin
      if (hit(regAddr, `HPG_OFS_DIR) && HAS_ADDR_PINS) begin
        st_next.rdata = st_reg.dir;
      end
      if (hit(regAddr, `HPG_OFS_DATA) && HAS_ADDR_PINS) begin
        st_next.rdata = (haSync & ~st_reg.dir) | (st_reg.dataOut & st_reg.dir);
      end
      if (hit(regAddr, `HPG_OFS_INT_EN)) begin
        st_next.rdata[`HPG_BIT_STROBE] = st_reg.intEn;
      end
      if (hit(regAddr, `HPG_OFS_INT_INV)) begin
        st_next.rdata[`HPG_BIT_STROBE] = st_reg.intInv;
      end
      if (hit(regAddr, `HPG_OFS_BANK_EN)) begin
        st_next.rdata[2:0] = st_reg.bankEn;
      end
      if (hit(regAddr, `HPG_OFS_MODE)) begin
        st_next.rdata[`HPG_BIT_MODE_MUX8] = st_reg.mux8;
      end
      if (hit(regAddr, `HPG_OFS_CTRL_DIR)) begin
        st_next.rdata[`HPG_BIT_CTRL_STROBE] = st_reg.ctrlDir;
      end
      if (hit(regAddr, `HPG_OFS_STATUS)) begin
        st_next.rdata[`HPG_BIT_STAT_CPU] = st_reg.status;
      end
      if (hit(regAddr, `HPG_OFS_MASK)) begin
        st_next.rdata[`HPG_BIT_STAT_CPU] = st_reg.mask;
      end
    end

    // pin drivers are registered so they never glitch while the enables settle
    st_next.haOe  = st_reg.dir & bankMask;
    st_next.haOut = st_reg.dataOut & st_reg.dir & bankMask;
    st_next.irq   = st_reg.status & st_reg.mask;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdata = st_reg.rdata;
  assign haOut    = st_reg.haOut;
  assign haOe     = st_reg.haOe;
  assign cpuIrq   = st_reg.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  reg_reset_a: assert property ($past(!rstn) |->
    (st_reg.dir == 16'h0000 && st_reg.dataOut == 16'h0000 && !st_reg.intEn && haOe == 16'h0000))
    else $error("registers not zero after reset");

  oe_gating_a: assert property (##1 haOe == ($past(st_reg.dir) & $past(bankMask)))
    else $error("output enable does not follow direction and bank enable");

  input_keep_a: assert property (
    (regWr && regAddr == `HPG_OFS_DATA)
    |=> ((st_reg.dataOut ^ $past(st_reg.dataOut)) & ~$past(st_reg.dir)) == 16'h0000)
    else $error("write changed an input pin data bit");

  output_drive_a: assert property (
    (regWr && regAddr == `HPG_OFS_DATA && HAS_ADDR_PINS && !st_reg.mux8
      && st_reg.bankEn[1:0] == 2'h3 && st_reg.dir == 16'hffff)
    |=> ##1 haOut == $past(regWdata, 2))
    else $error("written data not driven on output pins");

  read_input_a: assert property (
    (regRd && regAddr == `HPG_OFS_DATA && HAS_ADDR_PINS)
    |=> (regRdata & ~$past(st_reg.dir)) == ($past(haSync) & ~$past(st_reg.dir)))
    else $error("input pin level not returned on read");

  strobe_gate_a: assert property (strobeReq |->
    (st_reg.intEn && st_reg.bankEn[2] && !st_reg.ctrlDir && st_reg.mux8))
    else $error("strobe request without full configuration");

  strobe_sense_a: assert property (
    (st_reg.intEn && st_reg.bankEn[2] && !st_reg.ctrlDir && st_reg.mux8)
    |-> (strobeReq == (strobeSync ^ !st_reg.intInv)))
    else $error("strobe request has wrong sense");

  shared_request_a: assert property (
    ((strobeReq && !st_reg.reqPrev) || hostRise) |=> st_reg.status ##1 (cpuIrq == $past(st_reg.mask)))
    else $error("interrupt event did not set status");

  variant_inert_a: assert property (!HAS_ADDR_PINS |->
    (haOe == 16'h0000 && st_reg.dir == 16'h0000))
    else $error("address pin registers active on pinless variant");

  rdata_idle_a: assert property (
    !$past(regRd)
    |-> regRdata == 16'h0000)
    else $error("read data present without a read");

  en_reserved_a: assert property (
    (regRd && regAddr == `HPG_OFS_INT_EN)
    |=> (regRdata[15:3] == 13'h0000 && regRdata[1:0] == 2'h0))
    else $error("reserved enable bits read nonzero");

  inv_reserved_a: assert property (
    (regRd && regAddr == `HPG_OFS_INT_INV)
    |=> (regRdata[15:3] == 13'h0000 && regRdata[1:0] == 2'h0))
    else $error("reserved invert bits read nonzero");

  en_readback_a: assert property (
    (regRd && regAddr == `HPG_OFS_INT_EN)
    |=> regRdata[`HPG_BIT_STROBE] == $past(st_reg.intEn))
    else $error("interrupt enable bit reads back wrong");

  en_write_a: assert property (
    (regWr && regAddr == `HPG_OFS_INT_EN)
    |=> st_reg.intEn == $past(regWdata[`HPG_BIT_STROBE]))
    else $error("interrupt enable write did not land");

  inv_write_a: assert property (
    (regWr && regAddr == `HPG_OFS_INT_INV)
    |=> st_reg.intInv == $past(regWdata[`HPG_BIT_STROBE]))
    else $error("invert write did not land");

  dir_write_a: assert property (
    (regWr && regAddr == `HPG_OFS_DIR && HAS_ADDR_PINS)
    |=> st_reg.dir == $past(regWdata))
    else $error("direction write did not land");

  dir_read_a: assert property (
    (regRd && regAddr == `HPG_OFS_DIR && HAS_ADDR_PINS)
    |=> regRdata == $past(st_reg.dir))
    else $error("direction register reads back wrong");

  pinless_read_a: assert property (
    (!HAS_ADDR_PINS && regRd && (regAddr == `HPG_OFS_DIR || regAddr == `HPG_OFS_DATA))
    |=> regRdata == 16'h0000)
    else $error("pinless variant returned address pin data");

  out_undriven_a: assert property (
    (haOut & ~haOe)
    == 16'h0000)
    else $error("output value present on an undriven pin");

  status_sticky_a: assert property (
    (st_reg.status && !(regWr && regAddr == `HPG_OFS_STATUS && regWdata[`HPG_BIT_STAT_CPU]))
    |=> st_reg.status)
    else $error("interrupt status lost without a clear");

  status_clear_a: assert property (
    (regWr && regAddr == `HPG_OFS_STATUS && regWdata[`HPG_BIT_STAT_CPU]
      && !(strobeReq && !st_reg.reqPrev) && !hostRise) |=> !st_reg.status)
    else $error("interrupt status not cleared by write");

  mux8_pins_a: assert property (
    $past(st_reg.mux8)
    |-> haOe == 16'h0000)
    else $error("address pins driven in 8-bit mode");

endmodule

// ### testbench/hpg_host_model.sv
// host-side model of the address pins and the address-strobe pin
`timescale 1ns/1ps
module hpg_host_model (
  input  wire logic [15:0] haOe,
  input  wire logic [15:0] haOut,
  input  wire logic [15:0] hostVal,
  input  wire logic        strobeAct,
  input  wire logic        strobeInv,
  output logic      [15:0] haIn,
  output logic             strobeIn
);
  // the host lets go of every pin the device drives, so the wire shows the device level
  assign haIn = (haOe & haOut) | (~haOe & hostVal);
  // asserting means low unless the device was told to invert the sense
  assign strobeIn = strobeInv ? strobeAct : ~strobeAct;
endmodule

// ### testbench/hpg_gpio_tb.sv
// self-checking bench for the host-port pin block
`timescale 1ns/1ps
`include "hpg_consts.svh"
module hpg_gpio_tb;
  import hpg_pkg::*;
  logic       clk, rstn, regWr, regRd, strobeIn, hostIntBit, cpuIrq, strobeAct, strobeInv;
  logic [7:0] regAddr;
  hpg_word_t  regWdata, regRdata, rdata2, haIn, haOut, haOe, haOe2, hostVal;
  hpg_word_t  dir, dat, dataExp, rdA, rdB, bankMask;
  int         fail_count, check_count, cycles;
  logic [5:0] ic;
  // {strobe gpio, invert, int enable, strobe dir, 8-bit mode, mask}
  logic [5:0] icase [7] = '{6'h2b, 6'h3b, 6'h23, 6'h2f, 6'h29, 6'h2a, 6'h0b};
  logic [7:0] rstOfs [5] = '{`HPG_OFS_DIR, `HPG_OFS_DATA, `HPG_OFS_INT_EN, `HPG_OFS_INT_INV, 8'h3c};

  hpg_gpio #(.HAS_ADDR_PINS(1'b1)) hpg_gpio_inst (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .haIn(haIn),
    .haOut(haOut), .haOe(haOe), .strobeIn(strobeIn), .hostIntBit(hostIntBit), .cpuIrq(cpuIrq));
  // pinless variant shares the bus so every access is also tried on it
  hpg_gpio #(.HAS_ADDR_PINS(1'b0)) hpg_gpio_nopin_inst (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(rdata2), .haIn(hostVal),
    .haOut(), .haOe(haOe2), .strobeIn(strobeIn), .hostIntBit(hostIntBit), .cpuIrq());
  hpg_host_model hpg_host_model_inst (.haOe(haOe), .haOut(haOut), .hostVal(hostVal),
    .strobeAct(strobeAct), .strobeInv(strobeInv), .haIn(haIn), .strobeIn(strobeIn));

  function automatic logic reqExp(input logic [5:0] c);
    return c[5] & c[3] & !c[2] & c[1];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk); regAddr <= a; regWdata <= d; regWr <= 1'b1;
    @(posedge clk); regWr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk); regAddr <= a; regRd <= 1'b1;
    @(posedge clk); regRd <= 1'b0;
    #1; rdA = regRdata; rdB = rdata2;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    {rstn, regWr, regRd, hostIntBit, strobeAct, strobeInv} = '0;
    regAddr = '0; regWdata = '0; hostVal = '0; dataExp = '0;
    void'($urandom(32'h0e4b928d));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    foreach (rstOfs[k]) begin
      rd(rstOfs[k]); chk(rdA, 16'h0000);
    end
    chk(haOe, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      dir = (i == 0) ? 16'h0000 : (i == 5) ? 16'hffff : 16'($urandom);
      dat = 16'($urandom);
      hostVal <= 16'($urandom);
      wr(`HPG_OFS_BANK_EN, 16'h0003); wr(`HPG_OFS_DIR, dir); wr(`HPG_OFS_DATA, dat);
      // data bits of input pins must keep their old value
      dataExp = (dataExp & ~dir) | (dat & dir);
      tick(3);
      rd(`HPG_OFS_DATA); chk(rdA, (hostVal & ~dir) | (dataExp & dir));
      rd(`HPG_OFS_DIR); chk(rdA, dir);
      chk(rdB, 16'h0000);
      for (int b = 0; b < 4; b++) begin
        bankMask = {{8{b[1]}}, {8{b[0]}}};
        wr(`HPG_OFS_BANK_EN, 16'(b)); tick(2);
        chk(haOe, dir & bankMask);
        chk(haOut, dataExp & dir & bankMask);
      end
      wr(`HPG_OFS_MODE, 16'h0001); tick(2); chk(haOe, 16'h0000);
      wr(`HPG_OFS_MODE, 16'h0000); chk(haOe2, 16'h0000);
    end
    foreach (icase[k]) begin
      ic = icase[k];
      @(posedge clk); strobeAct <= 1'b0; strobeInv <= ic[4];
      wr(`HPG_OFS_BANK_EN, {13'h0, ic[5], 2'b11});
      wr(`HPG_OFS_MODE, {15'h0, ic[1]});
      wr(`HPG_OFS_CTRL_DIR, {15'h0, ic[2]});
      wr(`HPG_OFS_INT_INV, {13'h0, ic[4], 2'b00});
      wr(`HPG_OFS_MASK, {15'h0, ic[0]});
      wr(`HPG_OFS_INT_EN, {13'h0, ic[3], 2'b00});
      // the invert change can glitch a request while configuring, so start clean
      tick(4); wr(`HPG_OFS_STATUS, 16'h0001); tick(2); chk(cpuIrq, 1'b0);
      @(posedge clk); strobeAct <= 1'b1;
      tick(6); chk(cpuIrq, reqExp(ic) & ic[0]);
      rd(`HPG_OFS_STATUS); chk(rdA, {15'h0, reqExp(ic)});
      // a held level must not set the status again
      wr(`HPG_OFS_STATUS, 16'h0001); tick(3); chk(cpuIrq, 1'b0);
    end
    wr(`HPG_OFS_MASK, 16'h0001);
    @(posedge clk); hostIntBit <= 1'b1;
    tick(3); chk(cpuIrq, 1'b1);
    wr(`HPG_OFS_STATUS, 16'h0001); tick(2); chk(cpuIrq, 1'b0);
    end_of_test();
  end
endmodule
